// file: hw/pcc_chan.sv
`timescale 1ns/10ps
`default_nettype none
module pcc_chan (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	pcc_ch_if.chan ch
);
	logic [7:0] pre_cnt_ff;
	logic [8:0] sc_cnt_ff;
	logic [7:0] pre_mask;
	logic [9:0] sc_lim;
	logic gate, pre_tick, sc_tick;
	logic run_ff, out_ff, oe_ff, lvl_ff, cvld_ff, clvl_ff;
	logic [31:0] cnt_ff, per_ff, duty_ff, cc_ff, ccap_ff, per_eff, half_duty;
	logic [7:0] rep_ff;
	logic is_out, is_cap, last, start, act;

	// divider chain; gating only bites while the channel is idle
	assign gate = ch.lp && !ch.en; // [RULE_20]
	assign pre_mask = 8'((9'h001 << ch.pre) - 9'h001); // [RULE_23]
	assign pre_tick = !gate && ((pre_cnt_ff & pre_mask) == pre_mask);
	assign sc_lim = (ch.scale == 8'h00) ? pcc_pkg::DIV_ZERO_LIM : {1'b0, ch.scale, 1'b0};
	// >= so a divider shrunk on the fly recovers at once
	assign sc_tick = pre_tick && ({1'b0, sc_cnt_ff} >= (sc_lim - 10'h001)); // [RULE_22]
	assign ch.tick = ch.clk_sel ? sc_tick : pre_tick; // [RULE_23]

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_cnt_ff <= 8'h00;
			sc_cnt_ff <= 9'h000;
		end
		else if (ce)
		begin
			if (!gate)
				pre_cnt_ff <= pre_cnt_ff + 8'h01;
			if (pre_tick)
				sc_cnt_ff <= sc_tick ? 9'h000 : sc_cnt_ff + 9'h001;
		end
	end

	// waveform sequencing
	assign is_out = (ch.mode == pcc_pkg::PCC_ONESHOT) || (ch.mode == pcc_pkg::PCC_CONT); // [RULE_05]
	assign is_cap = (ch.mode == pcc_pkg::PCC_CAPT); // [RULE_05]
	assign per_eff = ch.center ? {per_ff[31:1], 1'b0} : per_ff; // [RULE_26]
	assign half_duty = {1'b0, duty_ff[31:1]};
	assign last = ({1'b0, cnt_ff} + 33'h000000001) >= {1'b0, per_eff};
	assign start = ch.en && is_out && !run_ff;
	assign ch.done = run_ff && ch.tick && last && (ch.mode == pcc_pkg::PCC_ONESHOT) && (rep_ff == ch.rpt); // [RULE_24]
	// center mode splits duty over both ends so the period still opens with it
	assign act = ch.center ? ((cnt_ff < half_duty) || (cnt_ff >= per_eff - half_duty)) : (cnt_ff < duty_ff); // [RULE_02]

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			run_ff <= 1'b0;
			cnt_ff <= pcc_pkg::RST_WORD;
			rep_ff <= 8'h00;
			per_ff <= pcc_pkg::RST_WORD;
			duty_ff <= pcc_pkg::RST_WORD;
		end
		else if (ce)
		begin
			if (start)
			begin
				run_ff <= 1'b1;
				cnt_ff <= pcc_pkg::RST_WORD;
				rep_ff <= 8'h00;
				if (!ch.lock)
				begin
					per_ff <= ch.period; // [RULE_01]
					duty_ff <= ch.duty;
				end
			end
			else if (!ch.en || !is_out)
				run_ff <= 1'b0; // [RULE_22]
			else if (run_ff && ch.tick)
			begin
				if (last)
				begin
					cnt_ff <= pcc_pkg::RST_WORD;
					rep_ff <= rep_ff + 8'h01;
					if (ch.done)
						run_ff <= 1'b0; // [RULE_06]
					if (!ch.lock)
					begin
						per_ff <= ch.period; // [RULE_21]
						duty_ff <= ch.duty;
					end
				end
				else
					cnt_ff <= cnt_ff + 32'h00000001;
			end
		end
	end

	// pin drive; released at reset and in capture
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_ff <= 1'b0;
			oe_ff <= 1'b0;
		end
		else if (ce)
		begin
			out_ff <= (run_ff && is_out) ? (act ? ch.act_lvl : !ch.act_lvl) : ch.idle_lvl; // [RULE_03] [RULE_04]
			oe_ff <= !is_cap;
		end
	end

	// capture: count ticks at one level, report on each input edge
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			lvl_ff <= 1'b0;
			cc_ff <= pcc_pkg::RST_WORD;
			cvld_ff <= 1'b0;
			clvl_ff <= 1'b0;
			ccap_ff <= pcc_pkg::RST_WORD;
		end
		else if (ce)
		begin
			cvld_ff <= 1'b0;
			if (!(ch.en && is_cap))
			begin
				cc_ff <= pcc_pkg::RST_WORD;
				lvl_ff <= ch.pin_in;
			end
			else if (ch.pin_in != lvl_ff)
			begin
				cvld_ff <= 1'b1; // [RULE_25]
				clvl_ff <= lvl_ff;
				ccap_ff <= cc_ff;
				// the cycle that first shows the new level is already one tick at it
				cc_ff <= ch.tick ? 32'h00000001 : pcc_pkg::RST_WORD;
				lvl_ff <= ch.pin_in;
			end
			else if (ch.tick)
				cc_ff <= cc_ff + 32'h00000001;
		end
	end

	assign ch.pin_out = out_ff;
	assign ch.pin_oe = oe_ff;
	assign ch.cap_vld = cvld_ff;
	assign ch.cap_lvl = clvl_ff;
	assign ch.cap_cnt = ccap_ff;
	assign ch.cnt = is_cap ? cc_ff : cnt_ff;

	a_idle_level: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
		(ce && !run_ff) |=> (ch.pin_out == $past(ch.idle_lvl)))
		else $error("idle level not driven");
	a_lock_hold: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
		(ce && run_ff && ch.lock) |=> $stable(per_ff) && $stable(duty_ff))
		else $error("locked period or duty changed");
	a_duty_first: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_04]
		(ce && run_ff && is_out && cnt_ff == 32'h00000000 && duty_ff > 32'h00000001)
		|=> (ch.pin_out == $past(ch.act_lvl)))
		else $error("period did not open with duty level");
endmodule : pcc_chan
`default_nettype wire

// file: hw/pcc_top.sv
// Behaviour
// RULE_01 - lock bit keeps the latched period and duty, ignoring new values
// RULE_02 - alignment bit: 0 left-aligned, 1 center-aligned output
// RULE_03 - disabled or finished one-shot channel drives the idle level
// RULE_04 - each period opens with the duty part at the active level
// RULE_05 - mode field: 00 one-shot, 01 continuous, 10 capture, 11 reserved
// RULE_06 - one-shot clears the channel enable itself after its periods
// RULE_07 - capture interrupt sets level flag to measured level; status write clears it
// RULE_08 - channel status bits set on channel events, cleared by writing one
// RULE_09 - enable bits let each channel status reach the interrupt; reset blocked
// RULE_10 - queue select makes channel 3 also push captures into the queue
// RULE_11 - queue control bit 8 enables the DMA request path
// RULE_12 - queue full and overflow raise flags when their enables are set
// RULE_13 - three-bit watermark level with its own interrupt enable
// RULE_14 - idle timeout flag after threshold PWM clock ticks when enabled
// RULE_15 - queue status: four write-one-clear flags plus read-only empty bit
// RULE_16 - queue word: level in bit 31, 31-bit count below
// RULE_17 - queue and DMA enabled in capture: request asserted for the DMA engine
// RULE_18 - software disables, configures everything, then enables the channel
// RULE_19 - one-shot end raises the channel interrupt as enable clears
// RULE_20 - low-power and inactive channel stops the predivider clock
// RULE_21 - new period or duty takes effect only at period end
// RULE_22 - mode and division may change while running; glitches tolerated
// RULE_23 - clock divided by 2^N, then by 2*factor (0 means 512); source select
// RULE_24 - repeat count N gives N+1 one-shot periods
// RULE_25 - capture stores high counts in period, low counts in duty register
// RULE_26 - center-aligned mode treats period bit 0 as zero
// RULE_27 - interrupt output high on any enabled channel or queue flag
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module pcc_top #(
	parameter int QDEPTH = 8,
	parameter int QAW = 3
) (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [3:0] PWM_IN,
	output logic [3:0] PWM_OUT,
	output logic [3:0] PWM_OE,
	output logic DMA_REQ,
	output logic IRQ
);
	localparam int N = pcc_pkg::NCH;
	localparam int Q = pcc_pkg::QCH;

	logic [31:0] ctrl_ff [N];
	logic [31:0] per_ff [N];
	logic [31:0] duty_ff [N];
	logic [31:0] ccnt [N];
	logic [31:0] cur_cnt [N];
	logic [N-1:0] done, tick, cvld, clvl, pout, poe, ch_ev, sts_clr;
	logic [N-1:0] sync1_ff, sync2_ff, ists_ff, lvlf_ff, ien_ff;
	logic [31:0] qctl_ff, rd_data, prdata_ff;
	logic [3:0] qsts_ff, q_ev, q_clr, q_ien;
	logic [pcc_pkg::LIM_W-1:0] qlim_ff, tout_ff;
	logic [31:0] q_mem [QDEPTH];
	logic [QAW-1:0] wr_ptr_ff, rd_ptr_ff;
	logic [QAW:0] q_cnt_ff;
	logic q_full, q_empty, push, push_ok, pop;
	logic pready_ff, pslverr_ff, irq_ff, dma_ff;
	logic wr_en, rd_en, setup, hit, wr_ch;
	logic [1:0] ch_sel;
	logic [3:0] sub;

	// pins come from outside, two stages before use
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sync1_ff <= 4'h0;
			sync2_ff <= 4'h0;
		end
		else if (CE)
		begin
			sync1_ff <= PWM_IN;
			sync2_ff <= sync1_ff;
		end
	end

	// bus phases; every access gets exactly one access cycle
	assign setup = PSEL && !PENABLE;
	assign wr_en = PSEL && PENABLE && PWRITE && pready_ff;
	assign rd_en = PSEL && PENABLE && !PWRITE && pready_ff;
	assign ch_sel = PADDR[pcc_pkg::CH_LSB +: 2];
	assign sub = PADDR[3:0];
	assign wr_ch = wr_en && (PADDR < pcc_pkg::OFS_CH_END);

	// per-channel engines and their registers
	for (genvar i = 0; i < N; i++)
	begin : g_ch
		pcc_ch_if u_if ();
		pcc_chan u_chan (
			.clk(CLOCK),
			.rst_n(RST_N),
			.ce(CE),
			.ch(u_if.chan)
		);
		assign u_if.en = ctrl_ff[i][pcc_pkg::B_EN];
		assign u_if.mode = pcc_pkg::pcc_mode_t'(ctrl_ff[i][pcc_pkg::B_MODE +: 2]);
		assign u_if.act_lvl = ctrl_ff[i][pcc_pkg::B_ACT];
		assign u_if.idle_lvl = ctrl_ff[i][pcc_pkg::B_IDLE];
		assign u_if.center = ctrl_ff[i][pcc_pkg::B_CENTER];
		assign u_if.lock = ctrl_ff[i][pcc_pkg::B_LOCK];
		assign u_if.lp = ctrl_ff[i][pcc_pkg::B_LP];
		assign u_if.clk_sel = ctrl_ff[i][pcc_pkg::B_CLKSEL];
		assign u_if.pre = ctrl_ff[i][pcc_pkg::B_PRE +: 3];
		assign u_if.scale = ctrl_ff[i][pcc_pkg::B_SCALE +: 8];
		assign u_if.rpt = ctrl_ff[i][pcc_pkg::B_RPT +: 8];
		assign u_if.period = per_ff[i];
		assign u_if.duty = duty_ff[i];
		assign u_if.pin_in = sync2_ff[i];
		assign done[i] = u_if.done;
		assign tick[i] = u_if.tick;
		assign cvld[i] = u_if.cap_vld;
		assign clvl[i] = u_if.cap_lvl;
		assign ccnt[i] = u_if.cap_cnt;
		assign cur_cnt[i] = u_if.cnt;
		assign pout[i] = u_if.pin_out;
		assign poe[i] = u_if.pin_oe;

		// hardware clear of enable and captured counts beat software writes
		always_ff @(posedge CLOCK or negedge RST_N)
		begin
			if (!RST_N)
			begin
				ctrl_ff[i] <= pcc_pkg::RST_WORD;
				per_ff[i] <= pcc_pkg::RST_WORD;
				duty_ff[i] <= pcc_pkg::RST_WORD;
			end
			else if (CE)
			begin
				if (wr_ch && ch_sel == 2'(i) && sub == pcc_pkg::OFS_CTRL[3:0])
					ctrl_ff[i] <= PWDATA & pcc_pkg::CTRL_MASK;
				if (done[i])
					ctrl_ff[i][pcc_pkg::B_EN] <= 1'b0; // [RULE_06] [RULE_19]
				if (cvld[i] && clvl[i])
					per_ff[i] <= ccnt[i]; // [RULE_25]
				else if (wr_ch && ch_sel == 2'(i) && sub == pcc_pkg::OFS_PER[3:0])
					per_ff[i] <= PWDATA;
				if (cvld[i] && !clvl[i])
					duty_ff[i] <= ccnt[i]; // [RULE_25]
				else if (wr_ch && ch_sel == 2'(i) && sub == pcc_pkg::OFS_DUTY[3:0])
					duty_ff[i] <= PWDATA;
			end
		end
	end

	// channel status; an event in the clearing cycle still sets
	assign ch_ev = done | cvld; // [RULE_19]
	assign sts_clr = (wr_en && PADDR == pcc_pkg::OFS_IRQ_STS) ? PWDATA[3:0] : 4'h0;

	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ists_ff <= 4'h0;
			lvlf_ff <= 4'h0;
			ien_ff <= 4'h0;
		end
		else if (CE)
		begin
			ists_ff <= ch_ev | (ists_ff & ~sts_clr); // [RULE_08]
			lvlf_ff <= (cvld & clvl) | (~cvld & lvlf_ff & ~sts_clr); // [RULE_07]
			if (wr_en && PADDR == pcc_pkg::OFS_IRQ_EN)
				ien_ff <= PWDATA[3:0]; // [RULE_09]
		end
	end

	// capture queue for channel 3
	assign q_full = (q_cnt_ff == (QAW+1)'(QDEPTH));
	assign q_empty = (q_cnt_ff == '0);
	assign push = cvld[Q] && qctl_ff[pcc_pkg::QB_SEL]; // [RULE_10]
	assign pop = rd_en && PADDR == pcc_pkg::OFS_Q_POP && !q_empty;
	// a full queue drops the new word; a pop in the same cycle makes room
	assign push_ok = push && (!q_full || pop);

	always_ff @(posedge CLOCK)
	begin
		if (CE && push_ok)
			q_mem[wr_ptr_ff] <= {clvl[Q], ccnt[Q][30:0]}; // [RULE_16]
	end

	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			q_cnt_ff <= '0;
		end
		else if (CE)
		begin
			if (push_ok)
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			if (push_ok && !pop)
				q_cnt_ff <= q_cnt_ff + 1'b1;
			else if (pop && !push_ok)
				q_cnt_ff <= q_cnt_ff - 1'b1;
		end
	end

	// idle timer runs on channel 3 ticks while words wait untouched
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			tout_ff <= '0;
		else if (CE)
		begin
			if (push_ok || pop || q_empty)
				tout_ff <= '0;
			else if (tick[Q] && tout_ff != '1)
				tout_ff <= tout_ff + 1'b1; // [RULE_14]
		end
	end

	// full, watermark and timeout flags are level conditions, so they re-set while still true; overflow is a one-cycle event
	assign q_ien = {qctl_ff[pcc_pkg::QB_TOUT], qctl_ff[pcc_pkg::QB_WM], qctl_ff[pcc_pkg::QB_OVF],
		qctl_ff[pcc_pkg::QB_FULL]};
	assign q_ev[0] = qctl_ff[pcc_pkg::QB_FULL] && q_full; // [RULE_12]
	assign q_ev[1] = qctl_ff[pcc_pkg::QB_OVF] && push && q_full && !pop; // [RULE_12]
	assign q_ev[2] = qctl_ff[pcc_pkg::QB_WM] && (q_cnt_ff >= {1'b0, qctl_ff[pcc_pkg::QB_WMLVL +: 3]}); // [RULE_13]
	assign q_ev[3] = qctl_ff[pcc_pkg::QB_TOUT] && !q_empty && (tout_ff >= qlim_ff); // [RULE_14]
	assign q_clr = (wr_en && PADDR == pcc_pkg::OFS_Q_STS) ? PWDATA[3:0] : 4'h0;

	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			qctl_ff <= pcc_pkg::RST_WORD;
			qlim_ff <= '0;
			qsts_ff <= 4'h0;
		end
		else if (CE)
		begin
			if (wr_en && PADDR == pcc_pkg::OFS_Q_CTRL)
				qctl_ff <= PWDATA & pcc_pkg::QCTL_MASK; // [RULE_11]
			if (wr_en && PADDR == pcc_pkg::OFS_Q_LIMIT)
				qlim_ff <= PWDATA[pcc_pkg::LIM_W-1:0];
			qsts_ff <= q_ev | (qsts_ff & ~q_clr); // [RULE_15]
		end
	end

	// register read map
	always_comb
	begin
		rd_data = pcc_pkg::RST_WORD;
		hit = 1'b1;
		if (PADDR < pcc_pkg::OFS_CH_END)
		begin
			if (sub == pcc_pkg::OFS_CNT[3:0])
				rd_data = cur_cnt[ch_sel];
			else if (sub == pcc_pkg::OFS_PER[3:0])
				rd_data = per_ff[ch_sel];
			else if (sub == pcc_pkg::OFS_DUTY[3:0])
				rd_data = duty_ff[ch_sel];
			else if (sub == pcc_pkg::OFS_CTRL[3:0])
				rd_data = ctrl_ff[ch_sel];
			else
				hit = 1'b0;
		end
		else if (PADDR == pcc_pkg::OFS_IRQ_STS)
			rd_data = {20'h00000, lvlf_ff, 4'h0, ists_ff}; // [RULE_07]
		else if (PADDR == pcc_pkg::OFS_IRQ_EN)
			rd_data = {28'h0000000, ien_ff};
		else if (PADDR == pcc_pkg::OFS_Q_CTRL)
			rd_data = qctl_ff;
		else if (PADDR == pcc_pkg::OFS_Q_STS)
			rd_data = {27'h0000000, q_empty, qsts_ff}; // [RULE_15]
		else if (PADDR == pcc_pkg::OFS_Q_LIMIT)
			rd_data = {12'h000, qlim_ff};
		else if (PADDR == pcc_pkg::OFS_Q_POP)
			rd_data = q_empty ? pcc_pkg::RST_WORD : q_mem[rd_ptr_ff]; // [RULE_16]
		else
			hit = 1'b0;
	end

	// answer registered in the setup cycle; head word cannot move before the pop
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			pready_ff <= 1'b0;
			prdata_ff <= pcc_pkg::RST_WORD;
			pslverr_ff <= 1'b0;
		end
		else if (CE)
		begin
			pready_ff <= setup;
			if (setup)
			begin
				prdata_ff <= PWRITE ? pcc_pkg::RST_WORD : rd_data;
				pslverr_ff <= !hit;
			end
		end
	end

	// interrupt and DMA request outputs
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			irq_ff <= 1'b0;
			dma_ff <= 1'b0;
		end
		else if (CE)
		begin
			irq_ff <= (|(ists_ff & ien_ff)) || (|(qsts_ff & q_ien)); // [RULE_09] [RULE_27]
			dma_ff <= qctl_ff[pcc_pkg::QB_DMA] && qctl_ff[pcc_pkg::QB_SEL] && !q_empty
				&& (ctrl_ff[Q][pcc_pkg::B_MODE +: 2] == pcc_pkg::PCC_CAPT); // [RULE_17]
		end
	end

	assign PRDATA = prdata_ff;
	assign PREADY = pready_ff;
	assign PSLVERR = pslverr_ff;
	assign PWM_OUT = pout;
	assign PWM_OE = poe;
	assign IRQ = irq_ff;
	assign DMA_REQ = dma_ff;

	a_sts_set_wins: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE_08]
		(CE && ch_ev[0]) |=> ists_ff[0])
		else $error("channel event lost");
	a_en_self_clear: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE_06]
		(CE && done[0]) |=> (!ctrl_ff[0][pcc_pkg::B_EN] && ists_ff[0]))
		else $error("one-shot end did not clear enable and flag");
	a_irq_raise: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE_27]
		(CE && |(ists_ff & ien_ff)) |=> IRQ)
		else $error("enabled status did not raise interrupt");
	a_irq_blocked: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE_09]
		(CE && ien_ff == 4'h0 && (qsts_ff & q_ien) == 4'h0) |=> !IRQ)
		else $error("blocked status raised interrupt");
	a_ovf_flag: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE_12]
		(CE && push && q_full && !pop && qctl_ff[pcc_pkg::QB_OVF]) |=> qsts_ff[1] && $stable(q_cnt_ff))
		else $error("overflow not flagged or word stored");
	a_dma_off: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RULE_11]
		(CE && !qctl_ff[pcc_pkg::QB_DMA]) |=> !DMA_REQ)
		else $error("DMA request while path disabled");
endmodule : pcc_top
`default_nettype wire

// file: include/pcc_ch_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pcc_ch_if;
	logic en, center, lock, idle_lvl, act_lvl, lp, clk_sel, pin_in;
	pcc_pkg::pcc_mode_t mode;
	logic [2:0] pre;
	logic [7:0] scale, rpt;
	logic [31:0] period, duty, cnt, cap_cnt;
	logic pin_out, pin_oe, done, tick, cap_vld, cap_lvl;
	modport ctl (output en, center, lock, idle_lvl, act_lvl, lp, clk_sel, pin_in, mode, pre, scale, rpt,
		period, duty, input cnt, cap_cnt, pin_out, pin_oe, done, tick, cap_vld, cap_lvl);
	modport chan (input en, center, lock, idle_lvl, act_lvl, lp, clk_sel, pin_in, mode, pre, scale, rpt,
		period, duty, output cnt, cap_cnt, pin_out, pin_oe, done, tick, cap_vld, cap_lvl);
endinterface : pcc_ch_if
`default_nettype wire

// file: include/pcc_pkg.sv
package pcc_pkg;
	localparam int NCH = 4;
	localparam int QCH = 3;
	localparam int CH_LSB = 4;
	// per-channel window, stride 0x10
	localparam logic [7:0] OFS_CNT = 8'h00;
	localparam logic [7:0] OFS_PER = 8'h04;
	localparam logic [7:0] OFS_DUTY = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h0c;
	localparam logic [7:0] OFS_CH_END = 8'h40;
	localparam logic [7:0] OFS_IRQ_STS = 8'h40;
	localparam logic [7:0] OFS_IRQ_EN = 8'h44;
	localparam logic [7:0] OFS_Q_CTRL = 8'h50;
	localparam logic [7:0] OFS_Q_STS = 8'h54;
	localparam logic [7:0] OFS_Q_LIMIT = 8'h58;
	localparam logic [7:0] OFS_Q_POP = 8'h60;
	// channel control fields
	localparam int B_EN = 0;
	localparam int B_MODE = 1;
	localparam int B_ACT = 3;
	localparam int B_IDLE = 4;
	localparam int B_CENTER = 5;
	localparam int B_LOCK = 6;
	localparam int B_LP = 8;
	localparam int B_CLKSEL = 9;
	localparam int B_PRE = 12;
	localparam int B_SCALE = 16;
	localparam int B_RPT = 24;
	localparam logic [31:0] CTRL_MASK = 32'hffff737f;
	// capture queue control and status fields
	localparam int QB_SEL = 0;
	localparam int QB_FULL = 1;
	localparam int QB_OVF = 2;
	localparam int QB_WM = 3;
	localparam int QB_WMLVL = 4;
	localparam int QB_DMA = 8;
	localparam int QB_TOUT = 9;
	localparam logic [31:0] QCTL_MASK = 32'h0000037f;
	localparam int LIM_W = 20;
	localparam logic [31:0] RST_WORD = 32'h00000000;
	localparam logic [9:0] DIV_ZERO_LIM = 10'h200;
	typedef enum logic [1:0] {
		PCC_ONESHOT = 2'b00,
		PCC_CONT = 2'b01,
		PCC_CAPT = 2'b10,
		PCC_RSVD = 2'b11
	} pcc_mode_t;
endpackage : pcc_pkg

// file: tb/pcc_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// far side of the waveform pins: follows driven pins, else plays a pulse train
module pcc_pin_model #(
	parameter int H = 6,
	parameter int L = 10
) (
	input wire logic clk,
	input wire logic run,
	input wire logic [3:0] oe,
	input wire logic [3:0] out,
	output logic [3:0] pin
);
	int cnt = 0;
	logic lvl = 1'b0;
	// a train stops only after a whole low phase, so no count is cut short
	always @(posedge clk)
	begin
		if (run || cnt != 0)
		begin
			lvl <= (cnt < H);
			cnt <= (cnt == H + L - 1) ? 0 : cnt + 1;
		end
		else
			lvl <= 1'b0;
	end
	// wire level: the block's drive wins wherever its enable is high
	always_comb
		for (int i = 0; i < 4; i++)
			pin[i] = oe[i] ? out[i] : lvl;
endmodule : pcc_pin_model
`default_nettype wire

// file: tb/tb_pwm_capture_controller.sv
`timescale 1ns/10ps
`default_nettype none
module tb_pwm_capture_controller;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic run = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rdv;
	logic pready, pslverr, errv, dma_req, irq;
	logic [3:0] pin, pout, poe;
	int bad_count = 0;
	int tests_run = 0;
	int n, w;

	// 25 MHz clock
	always #20 clk = ~clk;

	pcc_top #(.QDEPTH(8), .QAW(3)) uut (.CLOCK(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .PWM_IN(pin), .PWM_OUT(pout), .PWM_OE(poe), .DMA_REQ(dma_req), .IRQ(irq));

	pcc_pin_model #(.H(6), .L(10)) far (.clk(clk), .run(run), .oe(poe), .out(pout), .pin(pin));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		tests_run++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask : chk

	// one apb transfer; waits for pready, takes data at that edge only
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// high time of one whole period, measured from a fresh rising edge
	task automatic width(input int c);
		w = 0;
		while (pout[c] !== 1'b0) @(posedge clk);
		while (pout[c] !== 1'b1) @(posedge clk);
		while (pout[c] === 1'b1)
		begin
			@(posedge clk);
			w++;
		end
	endtask : width

	task automatic check_reset();
		logic [7:0] ofs [5] = '{8'h40, 8'h44, 8'h50, 8'h54, 8'h58};
		logic [31:0] val [5] = '{32'h0, 32'h0, 32'h0, 32'h10, 32'h0};
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b0, ofs[i], 32'h0);
			chk(rdv, val[i], "reset value");
		end
		apb(1'b0, 8'h70, 32'h0);
		chk(32'(errv), 32'h1, "unmapped error");
		apb(1'b1, 8'h44, 32'hffffffff);
		apb(1'b0, 8'h44, 32'h0);
		chk(rdv, 32'h0000000f, "enable width");
		apb(1'b1, 8'h44, 32'h00000001);
	endtask : check_reset

	// ch0 one-shot, two periods of 4 with duty 2, ch1 reserved mode
	task automatic one_shot();
		apb(1'b1, 8'h0c, 32'h01000008);
		apb(1'b1, 8'h04, 32'h4);
		apb(1'b1, 8'h08, 32'h2);
		apb(1'b1, 8'h1c, 32'h00000017);
		apb(1'b1, 8'h0c, 32'h01000009);
		n = 0;
		repeat (40)
		begin
			@(posedge clk);
			if (pout[0] === 1'b1) n++;
		end
		chk(32'(n), 32'h4, "one-shot active ticks");
		chk(32'(pout[0]), 32'h0, "idle after one-shot");
		chk(32'(pout[1]), 32'h1, "reserved mode idles");
		apb(1'b0, 8'h0c, 32'h0);
		chk(rdv & 32'h1, 32'h0, "enable self-cleared");
		apb(1'b0, 8'h40, 32'h0);
		chk(rdv & 32'h1, 32'h1, "one-shot status");
		chk(32'(irq), 32'h1, "irq raised");
		apb(1'b1, 8'h40, 32'h1);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0, "irq cleared");
	endtask : one_shot

	// ch2 continuous at prescale 2: duty update at period end, then frozen by lock
	// wait a whole period after each write so the measured period is a fresh one
	task automatic cont_lock();
		apb(1'b1, 8'h24, 32'h8);
		apb(1'b1, 8'h28, 32'h3);
		apb(1'b1, 8'h2c, 32'h0000100b);
		repeat (16) @(posedge clk);
		width(2);
		chk(32'(w), 32'h6, "continuous duty");
		apb(1'b1, 8'h28, 32'h5);
		repeat (16) @(posedge clk);
		width(2);
		chk(32'(w), 32'ha, "new duty taken");
		apb(1'b1, 8'h2c, 32'h0000104b);
		apb(1'b1, 8'h28, 32'h2);
		repeat (16) @(posedge clk);
		width(2);
		chk(32'(w), 32'ha, "locked duty kept");
		apb(1'b1, 8'h2c, 32'h0);
		repeat (3) @(posedge clk);
		chk(32'(pout[2]), 32'h0, "disabled idle");
	endtask : cont_lock

	// ch3 capture into the queue until it overflows, then drain as dma would
	task automatic capture_queue();
		apb(1'b1, 8'h58, 32'h00000014);
		apb(1'b1, 8'h50, 32'h0000033f);
		apb(1'b1, 8'h3c, 32'h00000005);
		repeat (3) @(posedge clk);
		chk(32'(poe[3]), 32'h0, "capture releases pin");
		run <= 1'b1;
		repeat (200) @(posedge clk);
		run <= 1'b0;
		repeat (40) @(posedge clk);
		chk(32'(dma_req), 32'h1, "dma request");
		chk(32'(irq), 32'h1, "queue irq");
		apb(1'b0, 8'h54, 32'h0);
		chk(rdv & 32'h1f, 32'h0f, "queue flags");
		apb(1'b0, 8'h40, 32'h0);
		chk(rdv & 32'h808, 32'h808, "level flag high");
		apb(1'b0, 8'h34, 32'h0);
		chk(rdv, 32'h6, "high count");
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b0, 8'h60, 32'h0);
			if (i > 0) chk(rdv, (i % 2) ? {1'b1, 31'd6} : {1'b0, 31'd10}, "queue word");
		end
		apb(1'b1, 8'h54, 32'hf);
		apb(1'b0, 8'h54, 32'h0);
		chk(rdv & 32'h1f, 32'h10, "drained and cleared");
		repeat (2) @(posedge clk);
		chk(32'(dma_req), 32'h0, "dma idle");
		chk(32'(irq), 32'h0, "ch3 status masked");
		apb(1'b1, 8'h40, 32'h8);
		apb(1'b0, 8'h40, 32'h0);
		chk(rdv & 32'h808, 32'h0, "level flag cleared");
	endtask : capture_queue

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	// main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		check_reset();
		one_shot();
		cont_lock();
		capture_queue();
		complete_run();
	end

	// watchdog, well beyond the several hundred cycles the run needs
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		complete_run();
	end
endmodule : tb_pwm_capture_controller
`default_nettype wire
